// [include/fbd_defs.vh]
/*
 Constants for the filament bridge and auxiliary output block:
 command addresses, field layouts, reset values, mode codes, timing.
 Assumes the block clock is the base oscillator (nominal 4 MHz).
*/
`ifndef FBD_DEFS_VH
`define FBD_DEFS_VH

// Command addresses (bit 7 of an incoming command marks a read)
`define FBD_ADDR_PUMP     7'h08
`define FBD_ADDR_ON_COUNT 7'h09
`define FBD_ADDR_LEG_A    7'h0A
`define FBD_ADDR_LEG_B    7'h0B
`define FBD_ADDR_AUX0     7'h0C
`define FBD_ADDR_AUX1     7'h0D
`define FBD_RD_BIT        7

// Field positions
`define FBD_LEG_SEL_MSB   1
`define FBD_AUX_SEL_MSB   2
`define FBD_PUMP_SEL_MSB  1

// Reset values
`define FBD_ON_COUNT_RST  8'h01
`define FBD_LEG_RST       2'h0
`define FBD_AUX0_RST      3'h0
`define FBD_AUX1_RST      3'h1
`define FBD_PUMP_RST      2'h0

// Bridge leg modes
`define FBD_LEG_LOW       2'h0
`define FBD_LEG_HIGH      2'h1
`define FBD_LEG_BLINK     2'h2
`define FBD_LEG_FIL       2'h3

// Auxiliary port modes
`define FBD_AUX_LOW       3'h0
`define FBD_AUX_HIGH      3'h1
`define FBD_AUX_BLINK     3'h2
`define FBD_AUX_DOUT      3'h3
`define FBD_AUX_T625      3'h4
`define FBD_AUX_T1250     3'h5
`define FBD_AUX_T2500     3'h6
`define FBD_AUX_RUN       3'h7

// Pump modes
`define FBD_PUMP_LOW      2'h0
`define FBD_PUMP_HIGH     2'h1
`define FBD_PUMP_SQUARE   2'h2
`define FBD_PUMP_DOUT     2'h3

// Timing, in oscillator cycles unless named otherwise
`define FBD_OSC_HZ        4000000
`define FBD_PERIOD_CYC    400
`define FBD_IDLE_BASE     9'h0C7
`define FBD_ON_MIN        8'h01
`define FBD_ON_MAX        8'hC7
`define FBD_COMM_NS       500
`define FBD_COMM_CYC      ((`FBD_COMM_NS * (`FBD_OSC_HZ / 1000000) + 999) / 1000)
`define FBD_TONE_HI_HZ    2500
`define FBD_TONE_HALF     (`FBD_OSC_HZ / (2 * `FBD_TONE_HI_HZ))
`define FBD_PUMP_DIV      50
`define FBD_PUMP_HALF     (`FBD_PUMP_DIV / 2)

`endif

// [core/fbd_top.v]
/*
 Filament full-bridge generator with bridge leg, auxiliary port and
 pump output selectors, plus the digit multiplex period timer.
 Assumes: clock is the base oscillator; commands arrive already
 decoded from the serial interface on the same clock; shutdown,
 blink phase and serial data out come from logic on the same clock.
*/
`timescale 1ns/10ps
`include "fbd_defs.vh"

module fbd_top #(
	parameter PERIOD_CYC = `FBD_PERIOD_CYC, // Cycles per filament period
	parameter COMM_CYC   = `FBD_COMM_CYC,   // Commutation gap length
	parameter TONE_HALF  = `FBD_TONE_HALF,  // Half period of top tone
	parameter PUMP_HALF  = `FBD_PUMP_HALF,  // Half period of pump wave
	parameter GRID_W     = 6                // Width of grid index
) (
	input  wire              clock,            // Base oscillator
	input  wire              reset,            // Async, active high
	input  wire              cmd_valid,        // Command strobe
	input  wire [7:0]        cmd_addr,         // Bit 7 set means read
	input  wire [7:0]        cmd_data,         // Write data
	input  wire              shutdown,         // Device is shut down
	input  wire              blink_phase,      // 0 first, 1 second phase
	input  wire              serial_dout,      // Serial data out level
	input  wire [GRID_W-1:0] grid_count,       // Grids minus one
	output reg               bridge_leg_a_out, // Bridge leg A
	output reg               bridge_leg_b_out, // Bridge leg B
	output reg               aux_out_zero,     // Auxiliary port 0
	output reg               aux_out_one,      // Auxiliary port 1
	output reg               pump_out,         // Charge pump output
	output reg  [7:0]        rd_data,          // Read answer
	output reg               rd_valid,         // Read answer strobe
	output reg  [GRID_W-1:0] scan_grid,        // Grid being lit
	output reg               digit_strobe      // Start of digit period
);

	// Sized copies of timing parameters for the 9-bit period, 12-bit tone and 6-bit pump counters
	localparam [8:0] PERIOD_LAST = PERIOD_CYC[8:0] - 9'h001;
	localparam [8:0] COMM_LEN    = COMM_CYC[8:0];
	localparam [11:0] TONE_LAST  = TONE_HALF[11:0] - 12'h001;
	localparam [5:0] PUMP_LAST   = PUMP_HALF[5:0] - 6'h01;

	// Stored command registers
	reg  [7:0] filament_on_count;   // Raw on-count as written
	reg  [1:0] leg_a_output_select; // Leg A mode
	reg  [1:0] leg_b_output_select; // Leg B mode
	reg  [2:0] aux0_select;         // Aux port 0 mode
	reg  [2:0] aux1_select;         // Aux port 1 mode
	reg  [1:0] pump_select;         // Pump mode

	// Timing state
	reg  [8:0] period_cnt;          // Position within filament period
	reg  [7:0] on_live;             // On-count in force this period
	reg  [11:0] tone_cnt;           // Divider to top tone half period
	reg  [2:0] tone_bits;           // Tone waves 2500, 1250, 625 Hz
	reg  [5:0] pump_cnt;            // Pump half period divider
	reg        pump_wave;           // Pump square wave
	reg  [7:0] on_clamped;          // On-count for the next period

	// Command decode
	wire       is_read  = cmd_addr[`FBD_RD_BIT];
	wire [6:0] reg_addr = cmd_addr[6:0];
	wire       wr_en    = cmd_valid & ~is_read;
	wire       rd_en    = cmd_valid & is_read;

	// Filament segment boundaries
	wire [8:0] on9      = {1'b0, on_live};
	wire [8:0] idle_len = `FBD_IDLE_BASE - on9;
	wire [8:0] b_end    = idle_len + on9;
	wire [8:0] gap_end  = b_end + COMM_LEN;
	wire [8:0] a_end    = gap_end + on9;
	wire       period_end = (period_cnt == PERIOD_LAST);

	// Raw filament waveforms before mode selection; both low elsewhere
	wire       fil_b = (period_cnt >= idle_len) && (period_cnt < b_end);
	wire       fil_a = (period_cnt >= gap_end) && (period_cnt < a_end);

	// Next output values
	reg        next_leg_a;
	reg        next_leg_b;
	reg        next_aux0;
	reg        next_aux1;
	reg        next_pump;
	reg  [7:0] next_rd_data;

	// Register writes; selector upper bits dropped, other blocks' addresses ignored
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			filament_on_count   <= `FBD_ON_COUNT_RST;
			leg_a_output_select <= `FBD_LEG_RST;
			leg_b_output_select <= `FBD_LEG_RST;
			aux0_select         <= `FBD_AUX0_RST;
			aux1_select         <= `FBD_AUX1_RST;
			pump_select         <= `FBD_PUMP_RST;
		end else if (wr_en) begin
			if (reg_addr == `FBD_ADDR_ON_COUNT) begin
				filament_on_count <= cmd_data;
			end else if (reg_addr == `FBD_ADDR_LEG_A) begin
				leg_a_output_select <= cmd_data[`FBD_LEG_SEL_MSB:0];
			end else if (reg_addr == `FBD_ADDR_LEG_B) begin
				leg_b_output_select <= cmd_data[`FBD_LEG_SEL_MSB:0];
			end else if (reg_addr == `FBD_ADDR_AUX0) begin
				aux0_select <= cmd_data[`FBD_AUX_SEL_MSB:0];
			end else if (reg_addr == `FBD_ADDR_AUX1) begin
				aux1_select <= cmd_data[`FBD_AUX_SEL_MSB:0];
			end else if (reg_addr == `FBD_ADDR_PUMP) begin
				pump_select <= cmd_data[`FBD_PUMP_SEL_MSB:0];
			end
		end
	end

	// Read mux; unmapped addresses answer zero
	always @* begin
		next_rd_data = 8'h00;
		if (reg_addr == `FBD_ADDR_ON_COUNT) begin
			next_rd_data = filament_on_count;
		end else if (reg_addr == `FBD_ADDR_LEG_A) begin
			next_rd_data = {6'h00, leg_a_output_select};
		end else if (reg_addr == `FBD_ADDR_LEG_B) begin
			next_rd_data = {6'h00, leg_b_output_select};
		end else if (reg_addr == `FBD_ADDR_AUX0) begin
			next_rd_data = {5'h00, aux0_select};
		end else if (reg_addr == `FBD_ADDR_AUX1) begin
			next_rd_data = {5'h00, aux1_select};
		end else if (reg_addr == `FBD_ADDR_PUMP) begin
			next_rd_data = {6'h00, pump_select};
		end
	end

	// Read answer, one cycle after the command
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			rd_data  <= 8'h00;
			rd_valid <= 1'b0;
		end else begin
			rd_valid <= rd_en;
			if (rd_en) begin
				rd_data <= next_rd_data;
			end
		end
	end

	// Out-of-range on-counts would break the 400-cycle period
	always @* begin
		on_clamped = filament_on_count;
		if (filament_on_count < `FBD_ON_MIN) begin
			on_clamped = `FBD_ON_MIN;
		end else if (filament_on_count > `FBD_ON_MAX) begin
			on_clamped = `FBD_ON_MAX;
		end
	end

	// Period counter for filament and digit multiplex; the on-count is taken
	// only at a period boundary, so a write never gives a short half cycle
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			period_cnt <= 9'h000;
			on_live    <= `FBD_ON_COUNT_RST;
		end else if (period_end) begin
			period_cnt <= 9'h000;
			on_live    <= on_clamped;
		end else begin
			period_cnt <= period_cnt + 9'h001;
		end
	end

	// Digit multiplex: one grid per period, wrap after grid_count
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			scan_grid    <= {GRID_W{1'b0}};
			digit_strobe <= 1'b0;
		end else begin
			digit_strobe <= period_end;
			if (period_end) begin
				if (scan_grid >= grid_count) begin
					scan_grid <= {GRID_W{1'b0}};
				end else begin
					scan_grid <= scan_grid + 1'b1;
				end
			end
		end
	end

	// Tone divider; one base counter feeds all three tones so they
	// stay phase locked to each other for bridge sounder drive
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			tone_cnt  <= 12'h000;
			tone_bits <= 3'h0;
		end else if (tone_cnt == TONE_LAST) begin
			tone_cnt  <= 12'h000;
			tone_bits <= tone_bits + 3'h1;
		end else begin
			tone_cnt <= tone_cnt + 12'h001;
		end
	end

	// Pump square wave divider
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			pump_cnt  <= 6'h00;
			pump_wave <= 1'b0;
		end else if (pump_cnt == PUMP_LAST) begin
			pump_cnt  <= 6'h00;
			pump_wave <= ~pump_wave;
		end else begin
			pump_cnt <= pump_cnt + 6'h01;
		end
	end

	// Leg A mode selection; filament drive uses the second half only
	always @* begin
		case (leg_a_output_select)
			`FBD_LEG_LOW: begin
				next_leg_a = 1'b0;
			end
			`FBD_LEG_HIGH: begin
				next_leg_a = 1'b1;
			end
			`FBD_LEG_BLINK: begin
				next_leg_a = blink_phase;
			end
			default: begin
				next_leg_a = fil_a & ~shutdown;
			end
		endcase
	end

	// Leg B mode selection; filament drive uses the first half only
	always @* begin
		case (leg_b_output_select)
			`FBD_LEG_LOW: begin
				next_leg_b = 1'b0;
			end
			`FBD_LEG_HIGH: begin
				next_leg_b = 1'b1;
			end
			`FBD_LEG_BLINK: begin
				next_leg_b = blink_phase;
			end
			default: begin
				next_leg_b = fil_b & ~shutdown;
			end
		endcase
	end

	// Aux port 0 selection; tones are silenced in shutdown
	always @* begin
		case (aux0_select)
			`FBD_AUX_LOW: begin
				next_aux0 = 1'b0;
			end
			`FBD_AUX_HIGH: begin
				next_aux0 = 1'b1;
			end
			`FBD_AUX_BLINK: begin
				next_aux0 = blink_phase;
			end
			`FBD_AUX_DOUT: begin
				next_aux0 = serial_dout;
			end
			`FBD_AUX_T625: begin
				next_aux0 = tone_bits[2] & ~shutdown;
			end
			`FBD_AUX_T1250: begin
				next_aux0 = tone_bits[1] & ~shutdown;
			end
			`FBD_AUX_T2500: begin
				next_aux0 = tone_bits[0] & ~shutdown;
			end
			default: begin
				next_aux0 = ~shutdown;
			end
		endcase
	end

	// Aux port 1: first four as port 0, last four inverted
	always @* begin
		case (aux1_select)
			`FBD_AUX_LOW: begin
				next_aux1 = 1'b0;
			end
			`FBD_AUX_HIGH: begin
				next_aux1 = 1'b1;
			end
			`FBD_AUX_BLINK: begin
				next_aux1 = blink_phase;
			end
			`FBD_AUX_DOUT: begin
				next_aux1 = serial_dout;
			end
			`FBD_AUX_T625: begin
				next_aux1 = ~(tone_bits[2] & ~shutdown);
			end
			`FBD_AUX_T1250: begin
				next_aux1 = ~(tone_bits[1] & ~shutdown);
			end
			`FBD_AUX_T2500: begin
				next_aux1 = ~(tone_bits[0] & ~shutdown);
			end
			default: begin
				next_aux1 = shutdown;
			end
		endcase
	end

	// Pump selection
	always @* begin
		case (pump_select)
			`FBD_PUMP_LOW: begin
				next_pump = 1'b0;
			end
			`FBD_PUMP_HIGH: begin
				next_pump = 1'b1;
			end
			`FBD_PUMP_SQUARE: begin
				next_pump = pump_wave & ~shutdown;
			end
			default: begin
				next_pump = serial_dout;
			end
		endcase
	end

	// Pins come from flip-flops; the equal one-cycle lag on both legs keeps
	// the idle and gap lengths, so the gap still prevents shoot-through
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			bridge_leg_a_out <= 1'b0;
			bridge_leg_b_out <= 1'b0;
			aux_out_zero     <= 1'b0;
			aux_out_one      <= 1'b1;
			pump_out         <= 1'b0;
		end else begin
			bridge_leg_a_out <= next_leg_a;
			bridge_leg_b_out <= next_leg_b;
			aux_out_zero     <= next_aux0;
			aux_out_one      <= next_aux1;
			pump_out         <= next_pump;
		end
	end

endmodule // fbd_top

// [sim/fbd_bridge_model.sv]
/*
 Behavioural MOSFET full bridge across the filament.
 Assumes both gate drives are sampled on the block clock.
*/
`timescale 1ns/10ps
module fbd_bridge_model (
	input  wire logic        clock,   // Sampling clock
	input  wire logic        reset,   // Clears both counts
	input  wire logic        leg_a,   // Leg A gate drive
	input  wire logic        leg_b,   // Leg B gate drive
	output logic      [15:0] fwd_cnt, // Cycles of current via leg B
	output logic      [15:0] rev_cnt  // Cycles of current via leg A
);
	// Current flows only while exactly one leg is high; both high would short
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			fwd_cnt <= 16'h0000;
			rev_cnt <= 16'h0000;
		end else begin
			if (leg_b && !leg_a)
				fwd_cnt <= fwd_cnt + 16'h0001;
			if (leg_a && !leg_b)
				rev_cnt <= rev_cnt + 16'h0001;
		end
	end
endmodule // fbd_bridge_model

// [sim/fbd_top_sva.sv]
/*
 Checker on the ports of fbd_top.
 Assumes its selector copies follow the same write strobes as the design.
*/
`timescale 1ns/10ps
`include "fbd_defs.vh"
module fbd_top_sva (
	input wire logic       clock,
	input wire logic       reset,
	input wire logic       cmd_valid,
	input wire logic [7:0] cmd_addr,
	input wire logic [7:0] cmd_data,
	input wire logic       shutdown,
	input wire logic       blink_phase,
	input wire logic       bridge_leg_a_out,
	input wire logic       bridge_leg_b_out,
	input wire logic       aux_out_zero,
	input wire logic       aux_out_one,
	input wire logic       digit_strobe
);
	logic [1:0] ma, mb; // Leg selector copies
	logic [2:0] m0, m1; // Aux selector copies
	logic [8:0] fc;     // Cycles of steady drive
	logic [8:0] ar, br; // Current high runs
	logic [8:0] bh;     // Last finished B run
	logic [8:0] pc;     // Cycles since strobe
	logic       seen;   // A strobe was seen
	wire        fil = ma == 2'h3 && mb == 2'h3 && !shutdown;
	wire        wr = cmd_valid && !cmd_addr[7];
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	// Copies and run lengths; fc masks runs cut short by a mode change
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			ma <= 2'h0;
			mb <= 2'h0;
			m0 <= 3'h0;
			m1 <= 3'h1;
			fc <= 9'h000;
			ar <= 9'h000;
			br <= 9'h000;
			bh <= 9'h000;
			pc <= 9'h000;
			seen <= 1'b0;
		end else begin
			if (wr && cmd_addr[6:0] == `FBD_ADDR_LEG_A)
				ma <= cmd_data[1:0];
			if (wr && cmd_addr[6:0] == `FBD_ADDR_LEG_B)
				mb <= cmd_data[1:0];
			if (wr && cmd_addr[6:0] == `FBD_ADDR_AUX0)
				m0 <= cmd_data[2:0];
			if (wr && cmd_addr[6:0] == `FBD_ADDR_AUX1)
				m1 <= cmd_data[2:0];
			fc <= !fil ? 9'h000 : (fc == 9'h1FF ? fc : fc + 9'h001);
			ar <= bridge_leg_a_out ? ar + 9'h001 : 9'h000;
			br <= bridge_leg_b_out ? br + 9'h001 : 9'h000;
			if (!bridge_leg_b_out && br != 9'h000)
				bh <= br;
			pc <= digit_strobe ? 9'h000 : pc + 9'h001;
			seen <= seen | digit_strobe;
		end
	end
	// Gap between the two driven halves
	sequence gap_s;
		!bridge_leg_a_out ##1 !bridge_leg_a_out ##1 bridge_leg_a_out;
	endsequence
	a_gap_two: assert property (disable iff (reset || shutdown)
		fc > 9'd420 && $fell(bridge_leg_b_out) |-> gap_s) else $error("gap wrong");
	a_halves_equal: assert property (disable iff (reset || shutdown)
		fc > 9'd420 && $fell(bridge_leg_a_out) |-> ar == bh) else $error("halves differ");
	a_no_shoot: assert property (fc > 9'd1 |-> !(bridge_leg_a_out && bridge_leg_b_out))
		else $error("both legs high");
	a_period_len: assert property (seen && digit_strobe |-> pc == 9'd399)
		else $error("period wrong");
	a_reset_vals: assert property ($fell(reset) |->
		!bridge_leg_a_out && !bridge_leg_b_out && !aux_out_zero && aux_out_one)
		else $error("reset levels wrong");
	a_leg_high: assert property (ma == 2'h1 |=> bridge_leg_a_out)
		else $error("static high lost");
	a_blink_b: assert property (mb == 2'h2 |=> bridge_leg_b_out == $past(blink_phase))
		else $error("blink wrong");
	a_shut_low: assert property (ma == 2'h3 && shutdown |=> !bridge_leg_a_out)
		else $error("leg driven in shutdown");
	a_aux_inverse: assert property (m0 == m1 && m0[2] |=> aux_out_one != aux_out_zero)
		else $error("aux not inverted");
endmodule // fbd_top_sva

// [sim/tb_top.sv]
/*
 Bench for fbd_top: register table, bridge timing, shutdown, tones.
 Assumes shortened tone and pump counts; the bridge model sits on the legs.
*/
`timescale 1ns/10ps
`include "fbd_defs.vh"
module tb_top;
	localparam TH = 4; // Tone half period, shortened
	localparam PH = 2; // Pump half period, shortened
	logic        clock = 1'b0;
	logic        reset = 1'b1;
	logic        cmd_valid = 1'b0;
	logic [7:0]  cmd_addr = 8'h00;
	logic [7:0]  cmd_data = 8'h00;
	logic        shutdown = 1'b0;
	logic        blink_phase = 1'b0;
	logic        serial_dout = 1'b0;
	logic [5:0]  grid_count = 6'h02; // Three grids
	logic [2:0]  bc = 3'h0;          // Blink divider
	wire         bridge_leg_a_out, bridge_leg_b_out, aux_out_zero, aux_out_one;
	wire         pump_out, rd_valid, digit_strobe;
	wire  [7:0]  rd_data;
	wire  [5:0]  scan_grid;
	wire  [15:0] fwd, rev;
	int          error_cnt = 0;
	int          num_checks = 0;
	logic [7:0]  r;
	logic [8:0]  ca, cb;
	// Address, data, read-back; upper selector bits read as zero
	logic [23:0] rows [10] = '{24'h09C7C7, 24'h0AFF03, 24'h0A0101, 24'h0B0602, 24'h0CFB03,
		24'h0D0F07, 24'h0C0707, 24'h080703, 24'h0E5500, 24'h090000};
	// Written on-count, on-count in force
	logic [15:0] nt [5] = '{16'h0101, 16'h6464, 16'hC6C6, 16'h0001, 16'hFFC7};
	fbd_top #(.TONE_HALF(TH), .PUMP_HALF(PH)) dut (.clock(clock), .reset(reset),
		.cmd_valid(cmd_valid), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
		.shutdown(shutdown), .blink_phase(blink_phase), .serial_dout(serial_dout),
		.grid_count(grid_count), .bridge_leg_a_out(bridge_leg_a_out),
		.bridge_leg_b_out(bridge_leg_b_out), .aux_out_zero(aux_out_zero),
		.aux_out_one(aux_out_one), .pump_out(pump_out), .rd_data(rd_data),
		.rd_valid(rd_valid), .scan_grid(scan_grid), .digit_strobe(digit_strobe));
	fbd_bridge_model pm (.clock(clock), .reset(reset), .leg_a(bridge_leg_a_out),
		.leg_b(bridge_leg_b_out), .fwd_cnt(fwd), .rev_cnt(rev));
	always #4 clock = ~clock;
	// Free-running level inputs so blink and data paths see traffic
	always @(posedge clock) begin
		bc <= bc + 3'h1;
		serial_dout <= ~serial_dout;
		blink_phase <= bc[2];
	end
	task automatic complete_run();
		if (error_cnt == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One command; held until the taking edge
	task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
		@(posedge clock);
		cmd_valid <= 1'b1;
		cmd_addr <= ad;
		cmd_data <= dt;
		@(posedge clock);
		cmd_valid <= 1'b0;
	endtask
	// Read answer is registered on the taking edge and checked at the next falling edge
	task automatic rd(input logic [7:0] ad, output logic [7:0] dt);
		@(posedge clock);
		cmd_valid <= 1'b1;
		cmd_addr <= ad | 8'h80;
		@(posedge clock);
		cmd_valid <= 1'b0;
		@(negedge clock);
		chk(rd_valid, 1'b1);
		dt = rd_data;
	endtask
	// Bounded wait for the start of a period
	task automatic wait_strobe();
		int i;
		for (i = 0; i < 500; i++) begin
			@(negedge clock);
			if (digit_strobe === 1'b1)
				break;
		end
		if (i == 500) begin
			error_cnt++;
			complete_run();
		end
	endtask
	// Leg high time over one period
	task automatic cnt_legs();
		ca = 9'h000;
		cb = 9'h000;
		repeat (2) @(negedge clock);
		repeat (400) begin
			@(negedge clock);
			ca += bridge_leg_a_out;
			cb += bridge_leg_b_out;
		end
	endtask
	// One full period from a strobe, pins lag the counter by a cycle
	task automatic measure(input logic [7:0] n);
		logic [8:0]  na, nb, fa, fb;
		logic [15:0] f0, r0;
		logic [5:0]  sg;
		na = 9'h000;
		nb = 9'h000;
		fa = 9'h000;
		fb = 9'h000;
		f0 = 16'h0000;
		r0 = 16'h0000;
		sg = scan_grid;
		for (int k = 1; k <= 400; k++) begin
			@(negedge clock);
			// The model samples the pins one edge late, so its count starts here
			if (k == 1) begin
				f0 = fwd;
				r0 = rev;
			end
			if (bridge_leg_a_out === 1'b1) begin
				if (na == 9'h000)
					fa = 9'(k);
				na = na + 9'h001;
			end
			if (bridge_leg_b_out === 1'b1) begin
				if (nb == 9'h000)
					fb = 9'(k);
				nb = nb + 9'h001;
			end
		end
		chk(nb, n);
		chk(na, n);
		chk(fb, 9'd200 - n);
		chk(fa, 9'd202);
		chk(digit_strobe, 1'b1);
		chk(scan_grid, sg >= grid_count ? 6'h00 : sg + 6'h01);
		// One more edge lets the model take the period's last pin level
		@(negedge clock);
		chk(fwd - f0, n);
		chk(rev - r0, n);
	endtask
	initial begin
		repeat (6) @(posedge clock);
		reset <= 1'b0;
		@(negedge clock);
		chk({bridge_leg_a_out, bridge_leg_b_out, aux_out_zero, aux_out_one}, 4'h1);
		rd(`FBD_ADDR_ON_COUNT, r);
		chk(r, 8'h01);
		foreach (rows[i]) begin
			wr(rows[i][23:16], rows[i][15:8]);
			rd(rows[i][23:16], r);
			chk(r, rows[i][7:0]);
		end
		// On-count goes in before either leg enters drive
		wr(`FBD_ADDR_ON_COUNT, 8'h01);
		wr(`FBD_ADDR_LEG_A, 8'h03);
		wr(`FBD_ADDR_LEG_B, 8'h03);
		foreach (nt[j]) begin
			wr(`FBD_ADDR_ON_COUNT, nt[j][15:8]);
			wait_strobe();
			measure(nt[j][7:0]);
		end
		@(posedge clock);
		shutdown <= 1'b1;
		cnt_legs();
		chk(ca | cb, 9'h000);
		@(posedge clock);
		shutdown <= 1'b0;
		wr(`FBD_ADDR_LEG_B, 8'h00);
		cnt_legs();
		chk(cb, 9'h000);
		// Tones on both ports, pump square wave alongside
		wr(`FBD_ADDR_PUMP, 8'h02);
		for (int m = 4; m <= 6; m++) begin
			wr(`FBD_ADDR_AUX0, 8'(m));
			wr(`FBD_ADDR_AUX1, 8'(m));
			repeat (2) @(negedge clock);
			r = {aux_out_zero, pump_out, 6'h00};
			ca = 9'h000;
			cb = 9'h000;
			repeat (64) begin
				@(negedge clock);
				ca += aux_out_zero !== r[7];
				cb += pump_out !== r[6];
				r = {aux_out_zero, pump_out, 6'h00};
			end
			chk(ca, 16'(64 / (TH << (6 - m))));
			chk(cb, 16'(64 / PH));
		end
		@(posedge clock);
		shutdown <= 1'b1;
		repeat (2) @(negedge clock);
		chk({aux_out_zero, aux_out_one}, 2'h1);
		wr(`FBD_ADDR_AUX0, 8'h07);
		wr(`FBD_ADDR_AUX1, 8'h07);
		repeat (2) @(negedge clock);
		chk({aux_out_zero, aux_out_one}, 2'h1);
		@(posedge clock);
		shutdown <= 1'b0;
		repeat (2) @(negedge clock);
		chk({aux_out_zero, aux_out_one}, 2'h2);
		// Mid-run reset returns every selector to its power-up mode
		@(posedge clock);
		reset <= 1'b1;
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		@(negedge clock);
		chk({bridge_leg_a_out, bridge_leg_b_out, aux_out_zero, aux_out_one}, 4'h1);
		rd(`FBD_ADDR_LEG_A, r);
		chk(r, 8'h00);
		rd(`FBD_ADDR_AUX1, r);
		chk(r, 8'h01);
		complete_run();
	end
endmodule // tb_top
bind fbd_top fbd_top_sva chk_i (.clock(clock), .reset(reset), .cmd_valid(cmd_valid),
	.cmd_addr(cmd_addr), .cmd_data(cmd_data), .shutdown(shutdown),
	.blink_phase(blink_phase), .bridge_leg_a_out(bridge_leg_a_out),
	.bridge_leg_b_out(bridge_leg_b_out), .aux_out_zero(aux_out_zero),
	.aux_out_one(aux_out_one), .digit_strobe(digit_strobe));
